/* clk_tree_cfg.sv */
// clock tree configuration registers, source selectors and pll setting assembly
// assumes a synchronous 8-bit register port in the clk_i domain and clock inputs sampled as levels
`default_nettype none

// Functional notes
// - secondary bit-clock divider source bits 6-4: pll, primary, external, oscillator, dsp.
// - digital divider source bits 7-6: primary, secondary, external, oscillator.
// - divider source bits 5-4 reset 01; 0,1 pll, 2 digital, 3 primary.
// - prescaler divides by its code 1-255; code 0 divides by 256; reset 1.
// - automatic detection makes prescaler, integer and fraction fields ignored.
// - multiplier control bit 7 is the integer multiplier top bit.
// - multiplier control bit 6 set halves the divided clock.
// - multiplier control bits 5-0 are fraction top bits, reset zero.
// - fraction is the six top bits joined with the following low byte.
// - prescaler input source: primary, secondary, external, oscillator.
// - integer multiplier is top bit over low byte, 1 to 511; zero reserved.
module clk_tree_cfg
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic auto_detect_i,
  input wire logic [8:0] auto_prescale_i,
  input wire logic [8:0] auto_int_i,
  input wire logic [13:0] auto_frac_i,
  input wire clk_tree_pkg::clk_inputs_type clk_in_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output clk_tree_pkg::pll_settings_type pll_o,
  output logic sec_div_clk_o,
  output logic dig_nm_clk_o,
  output logic nm_div_clk_o,
  output logic prescale_clk_o,
  output clk_tree_pkg::clk_source_type sec_src_o,
  output clk_tree_pkg::clk_source_type nm_src_o
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] sec_src_reg;
  logic [7:0] nm_src_reg;
  logic [7:0] prescale_reg;
  logic [7:0] mult_upper_reg;
  logic [7:0] frac_low_reg;
  logic [7:0] int_low_reg;
  logic [7:0] pre_src_reg;

  // every register is a plain byte of flops; the fields are carved out further down
  // so that the read port returns the raw bytes the selectors and the manual pll settings are built from

  // address decode
  // each strobe already carries the clock enable, so a frozen block ignores writes
  wire wr_sec = ce_i && wr_en_i && (addr_i == clk_tree_pkg::SEC_SRC_ADDR);
  wire wr_nm = ce_i && wr_en_i && (addr_i == clk_tree_pkg::NM_SRC_ADDR);
  wire wr_pre = ce_i && wr_en_i && (addr_i == clk_tree_pkg::PRESCALE_ADDR);
  wire wr_mul = ce_i && wr_en_i && (addr_i == clk_tree_pkg::MULT_UPPER_ADDR);
  wire wr_frac = ce_i && wr_en_i && (addr_i == clk_tree_pkg::FRAC_LOW_ADDR);
  wire wr_int = ce_i && wr_en_i && (addr_i == clk_tree_pkg::INT_LOW_ADDR);
  wire wr_psrc = ce_i && wr_en_i && (addr_i == clk_tree_pkg::PRE_SRC_ADDR);

  // read-only reserved bits are masked so they keep reading zero whatever is written
  wire [7:0] sec_src_next = wdata_i & clk_tree_pkg::SEC_SRC_WMASK;
  wire [7:0] pre_src_next = wdata_i & clk_tree_pkg::PRE_SRC_WMASK;

  // register writes, frozen while the clock enable is low
  // each byte acts at once; a multi-byte setting passes through mixed values while
  // software rewrites it, which the pll side must tolerate or hold off on
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sec_src_reg <= clk_tree_pkg::SEC_SRC_RST;
      nm_src_reg <= clk_tree_pkg::NM_SRC_RST;
      prescale_reg <= clk_tree_pkg::PRESCALE_RST;
      mult_upper_reg <= clk_tree_pkg::MULT_UPPER_RST;
      frac_low_reg <= clk_tree_pkg::FRAC_LOW_RST;
      int_low_reg <= clk_tree_pkg::INT_LOW_RST;
      pre_src_reg <= clk_tree_pkg::PRE_SRC_RST;
    end
    else
    begin
      if (wr_sec) sec_src_reg <= sec_src_next;
      if (wr_nm) nm_src_reg <= wdata_i & clk_tree_pkg::FULL_WMASK;
      if (wr_pre) prescale_reg <= wdata_i;
      if (wr_mul) mult_upper_reg <= wdata_i;
      if (wr_frac) frac_low_reg <= wdata_i;
      if (wr_int) int_low_reg <= wdata_i;
      if (wr_psrc) pre_src_reg <= pre_src_next;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // unmapped addresses read zero; data lands one cycle after the request
  // a read and a write to one address in one cycle return the old value,
  // since the case below looks at the registers before the write edge
  logic [7:0] rdata_next;
  always_comb
  begin
    case (addr_i)
      clk_tree_pkg::SEC_SRC_ADDR: rdata_next = sec_src_reg;
      clk_tree_pkg::NM_SRC_ADDR: rdata_next = nm_src_reg;
      clk_tree_pkg::PRESCALE_ADDR: rdata_next = prescale_reg;
      clk_tree_pkg::MULT_UPPER_ADDR: rdata_next = mult_upper_reg;
      clk_tree_pkg::FRAC_LOW_ADDR: rdata_next = frac_low_reg;
      clk_tree_pkg::INT_LOW_ADDR: rdata_next = int_low_reg;
      clk_tree_pkg::PRE_SRC_ADDR: rdata_next = pre_src_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rdata_o <= rd_en_i ? rdata_next : rdata_o;
      rvalid_o <= rd_en_i;
    end
  end

  // ----------------------------------------------------------------
  // field extraction
  // field positions come from the package so the register map stays in one place
  // ----------------------------------------------------------------
  wire [2:0] sec_code = sec_src_reg[clk_tree_pkg::SEC_SRC_LSB +: 3];
  wire [1:0] dig_code = nm_src_reg[clk_tree_pkg::DIG_SRC_LSB +: 2];
  wire [1:0] nm_code = nm_src_reg[clk_tree_pkg::NM_SRC_LSB +: 2];
  wire [1:0] psrc_code = pre_src_reg[clk_tree_pkg::PRE_SRC_LSB +: 2];

  // ----------------------------------------------------------------
  // source selectors
  // ----------------------------------------------------------------
  // reserved codes select no clock and hold the divider input low, a safe idle
  // a quiet low was chosen over a default source so that a bad code is visible
  // as a dead divider instead of a divider running at an unexpected rate
  clk_tree_pkg::clk_source_type sec_src;
  always_comb
  begin
    case (sec_code)
      3'h0: sec_src = clk_tree_pkg::SRC_PLL;
      3'h1: sec_src = clk_tree_pkg::SRC_PRIMARY;
      3'h3: sec_src = clk_tree_pkg::SRC_EXTERNAL;
      3'h4: sec_src = clk_tree_pkg::SRC_OSC;
      3'h5: sec_src = clk_tree_pkg::SRC_DSP;
      default: sec_src = clk_tree_pkg::SRC_NONE;
    endcase
  end

  // the digital divider source and the pll prescaler source share one encoding
  // one function keeps the two decoders from drifting apart
  function automatic clk_tree_pkg::clk_source_type four_way(input logic [1:0] code);
    case (code)
      2'h0: four_way = clk_tree_pkg::SRC_PRIMARY;
      2'h1: four_way = clk_tree_pkg::SRC_SECONDARY;
      2'h2: four_way = clk_tree_pkg::SRC_EXTERNAL;
      default: four_way = clk_tree_pkg::SRC_OSC;
    endcase
  endfunction

  wire clk_tree_pkg::clk_source_type dig_src = four_way(dig_code);
  wire clk_tree_pkg::clk_source_type psrc_src = four_way(psrc_code);

  // codes 0 and 1 both take the pll output; code 3 is the low-jitter primary path
  clk_tree_pkg::clk_source_type nm_src;
  always_comb
  begin
    case (nm_code)
      2'h2: nm_src = clk_tree_pkg::SRC_DIGITAL;
      2'h3: nm_src = clk_tree_pkg::SRC_PRIMARY;
      default: nm_src = clk_tree_pkg::SRC_PLL;
    endcase
  end

  // one selector per divider input; only the n/m selector may take the digital source level
  logic sec_level;
  logic dig_level;
  logic nm_level;
  logic psrc_level;

  clk_source_pick i_sec_pick
  (
    .sel_i(sec_src),
    .clk_in_i(clk_in_i),
    .digital_i(1'b0),
    .level_o(sec_level)
  );

  clk_source_pick i_dig_pick
  (
    .sel_i(dig_src),
    .clk_in_i(clk_in_i),
    .digital_i(1'b0),
    .level_o(dig_level)
  );

  // the n/m chain reaches the digital source through the digital selector's own level
  clk_source_pick i_nm_pick
  (
    .sel_i(nm_src),
    .clk_in_i(clk_in_i),
    .digital_i(dig_level),
    .level_o(nm_level)
  );

  clk_source_pick i_psrc_pick
  (
    .sel_i(psrc_src),
    .clk_in_i(clk_in_i),
    .digital_i(1'b0),
    .level_o(psrc_level)
  );

  // ----------------------------------------------------------------
  // pll settings
  // ----------------------------------------------------------------
  wire [8:0] prescale_div = (prescale_reg == 8'h00) ? clk_tree_pkg::PRESCALE_ZERO_DIV
                                                    : {1'b0, prescale_reg};
  wire [8:0] int_mult = {mult_upper_reg[clk_tree_pkg::INT_TOP_BIT], int_low_reg};
  wire [13:0] frac_mult = {mult_upper_reg[clk_tree_pkg::FRAC_TOP_W-1:0], frac_low_reg};
  wire halve = mult_upper_reg[clk_tree_pkg::HALVE_BIT];
  // reserved programming is flagged, not corrected; the ratio is J + D/10000
  wire bad_setting = (int_mult == clk_tree_pkg::INT_ZERO) || (frac_mult > clk_tree_pkg::FRAC_LIMIT);

  // the block only hands over j, d, p, the halving bit and the manual and reserved flags; the ratio itself is
  // formed inside the pll, which lies outside this block
  // a limitation: the reserved flag is only a warning, the values still pass through

  // in auto detection the programmed fields other than the halving bit are ignored in favour of derived ones
  clk_tree_pkg::pll_settings_type pll_next;
  assign pll_next.prescale_div = auto_detect_i ? auto_prescale_i : prescale_div;
  assign pll_next.int_mult = auto_detect_i ? auto_int_i : int_mult;
  assign pll_next.frac_mult = auto_detect_i ? auto_frac_i : frac_mult;
  assign pll_next.halve = halve;
  assign pll_next.manual = ~auto_detect_i;
  assign pll_next.reserved_setting = ~auto_detect_i & bad_setting;

  // registered outputs; clock levels pass through one flop, fine for a behavioural tree
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pll_o <= '0;
      sec_div_clk_o <= 1'b0;
      dig_nm_clk_o <= 1'b0;
      nm_div_clk_o <= 1'b0;
      prescale_clk_o <= 1'b0;
      sec_src_o <= clk_tree_pkg::SRC_PLL;
      nm_src_o <= clk_tree_pkg::SRC_PLL;
    end
    else if (ce_i)
    begin
      pll_o <= pll_next;
      sec_div_clk_o <= sec_level;
      dig_nm_clk_o <= dig_level;
      nm_div_clk_o <= nm_level;
      prescale_clk_o <= psrc_level;
      sec_src_o <= sec_src;
      nm_src_o <= nm_src;
    end
  end

endmodule // clk_tree_cfg

// ----------------------------------------------------------------
// clock source selector
// ----------------------------------------------------------------
// picks one clock level by source identity; reserved identities give a quiet low
// purely combinational, the caller registers the result before it leaves the block
module clk_source_pick
(
  input wire clk_tree_pkg::clk_source_type sel_i,
  input wire clk_tree_pkg::clk_inputs_type clk_in_i,
  input wire logic digital_i,
  output logic level_o
);

  // level selection by source identity
  always_comb
  begin
    case (sel_i)
      clk_tree_pkg::SRC_PLL: level_o = clk_in_i.pll;
      clk_tree_pkg::SRC_PRIMARY: level_o = clk_in_i.primary;
      clk_tree_pkg::SRC_SECONDARY: level_o = clk_in_i.secondary;
      clk_tree_pkg::SRC_EXTERNAL: level_o = clk_in_i.external_clock;
      clk_tree_pkg::SRC_OSC: level_o = clk_in_i.osc;
      clk_tree_pkg::SRC_DSP: level_o = clk_in_i.dsp;
      clk_tree_pkg::SRC_DIGITAL: level_o = digital_i;
      default: level_o = 1'b0;
    endcase
  end

endmodule // clk_source_pick

`default_nettype wire

/* clk_tree_pkg.sv */
// clock tree configuration package: register offsets, field layouts, reset values, source codes
// assumes an 8-bit register port with a 7-bit address, as on the device control port
`default_nettype none

package clk_tree_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] SEC_SRC_ADDR = 7'h33;
  localparam logic [6:0] NM_SRC_ADDR = 7'h34;
  localparam logic [6:0] PRESCALE_ADDR = 7'h35;
  localparam logic [6:0] MULT_UPPER_ADDR = 7'h36;
  localparam logic [6:0] FRAC_LOW_ADDR = 7'h37;
  localparam logic [6:0] INT_LOW_ADDR = 7'h38;
  localparam logic [6:0] PRE_SRC_ADDR = 7'h32;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SEC_SRC_RST = 8'h00;
  localparam logic [7:0] NM_SRC_RST = 8'h10;
  localparam logic [7:0] PRESCALE_RST = 8'h01;
  localparam logic [7:0] MULT_UPPER_RST = 8'h00;
  localparam logic [7:0] FRAC_LOW_RST = 8'h00;
  localparam logic [7:0] INT_LOW_RST = 8'h08;
  localparam logic [7:0] PRE_SRC_RST = 8'h00;

  // ----------------------------------------------------------------
  // writable masks; other bits are read-only reserved and read as zero
  // ----------------------------------------------------------------
  localparam logic [7:0] SEC_SRC_WMASK = 8'h70;
  localparam logic [7:0] PRE_SRC_WMASK = 8'hC0;
  localparam logic [7:0] FULL_WMASK = 8'hFF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SEC_SRC_LSB = 4;
  localparam int DIG_SRC_LSB = 6;
  localparam int NM_SRC_LSB = 4;
  localparam int PRE_SRC_LSB = 6;
  localparam int INT_TOP_BIT = 7;
  localparam int HALVE_BIT = 6;
  localparam int FRAC_TOP_W = 6;

  // ----------------------------------------------------------------
  // derived values
  // ----------------------------------------------------------------
  localparam logic [8:0] PRESCALE_ZERO_DIV = 9'h100;
  localparam logic [13:0] FRAC_LIMIT = 14'h270F;
  localparam logic [8:0] INT_ZERO = 9'h000;

  // binary-coded clock source identities on the selector inputs and source outputs
  typedef enum logic [2:0]
  {
    SRC_PLL = 3'b000,
    SRC_PRIMARY = 3'b001,
    SRC_SECONDARY = 3'b010,
    SRC_EXTERNAL = 3'b011,
    SRC_OSC = 3'b100,
    SRC_DSP = 3'b101,
    SRC_DIGITAL = 3'b110,
    SRC_NONE = 3'b111
  } clk_source_type;

  // clock inputs to the selectors
  typedef struct packed
  {
    logic pll;
    logic primary;
    logic secondary;
    logic external_clock;
    logic osc;
    logic dsp;
  } clk_inputs_type;

  // settings delivered to the pll
  typedef struct packed
  {
    logic [8:0] prescale_div;
    logic [8:0] int_mult;
    logic [13:0] frac_mult;
    logic halve;
    logic manual;
    logic reserved_setting;
  } pll_settings_type;

endpackage : clk_tree_pkg

`default_nettype wire

/* clk_tree_cfg_monitor.sv */
// checker for the clock tree configuration block
// assumes it is bound to clk_tree_cfg and sees only its ports
`default_nettype none

module clk_tree_cfg_monitor
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic rd_en_i,
  input wire logic [6:0] addr_i,
  input wire logic auto_detect_i,
  input wire logic [8:0] auto_prescale_i,
  input wire logic [8:0] auto_int_i,
  input wire clk_tree_pkg::clk_inputs_type clk_in_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire clk_tree_pkg::pll_settings_type pll_o,
  input wire logic sec_div_clk_o,
  input wire logic nm_div_clk_o,
  input wire clk_tree_pkg::clk_source_type sec_src_o,
  input wire clk_tree_pkg::clk_source_type nm_src_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_read_pulse: assert property (ce_i && rd_en_i |=> rvalid_o) else $error("read gave no valid pulse");
  a_sec_reserved_zero: assert property (ce_i && rd_en_i && addr_i == clk_tree_pkg::SEC_SRC_ADDR
    |=> (rdata_o & ~clk_tree_pkg::SEC_SRC_WMASK) == 8'h00) else $error("reserved bits read nonzero");
  a_unmapped_zero: assert property (ce_i && rd_en_i && addr_i > 7'h38 |=> rdata_o == 8'h00)
    else $error("unmapped read nonzero");
  // past guards skip the first edge after reset, where inputs were sampled in reset
  a_sec_pll_route: assert property ($past(rstn_i) && $past(ce_i) && sec_src_o == clk_tree_pkg::SRC_PLL
    |-> sec_div_clk_o == $past(clk_in_i.pll)) else $error("secondary divider not on pll");
  a_nm_primary_route: assert property ($past(rstn_i) && $past(ce_i) && nm_src_o == clk_tree_pkg::SRC_PRIMARY
    |-> nm_div_clk_o == $past(clk_in_i.primary)) else $error("divider not on primary clock");
  a_auto_override: assert property (ce_i && auto_detect_i |=> !pll_o.manual
    && pll_o.prescale_div == $past(auto_prescale_i) && pll_o.int_mult == $past(auto_int_i))
    else $error("auto settings not applied");
  a_manual_flag: assert property (ce_i && !auto_detect_i |=> pll_o.manual) else $error("manual flag low");
  a_zero_int_flag: assert property (pll_o.manual && pll_o.int_mult == 9'h000 |-> pll_o.reserved_setting)
    else $error("zero integer not flagged");
  a_prescale_range: assert property (pll_o.manual |-> pll_o.prescale_div inside {[9'h001:9'h100]})
    else $error("prescale out of range");

  // main scenarios seen
  c_auto: cover property (ce_i && auto_detect_i);
  c_flag: cover property (pll_o.reserved_setting);
  c_digital: cover property (nm_src_o == clk_tree_pkg::SRC_DIGITAL);
endmodule // clk_tree_cfg_monitor

bind clk_tree_cfg clk_tree_cfg_monitor i_mon (.*);

`default_nettype wire

/* clk_tree_host.sv */
// host model: writes and reads the clock registers over the register port
// assumes one clock; requests change just after a rising edge
`default_nettype none

module clk_tree_host
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic ce_o,
  output logic wr_o,
  output logic rd_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle port at time zero
  initial
  begin
    ce_o = 1'b1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 7'h00;
    wdata_o = 8'h00;
  end

  // one write; callers never pick reserved source codes or fractions
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= (a == clk_tree_pkg::SEC_SRC_ADDR) ? (d & clk_tree_pkg::SEC_SRC_WMASK) : d;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask

  // one write offered while the clock enable is low; the block must ignore it
  task automatic wr_frozen(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ce_o <= 1'b0;
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    ce_o <= 1'b1;
    wr_o <= 1'b0;
  endtask

  // one read; data and valid are taken just after the answering edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule // clk_tree_host

`default_nettype wire

/* audio_clock_tree_pll_divider_config_tb.sv */
// testbench for the clock tree configuration block
// assumes the host model drives the register port; clock inputs are levels set here
`default_nettype none

module audio_clock_tree_pll_divider_config_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce, wr, rd, rvalid, auto, sclk, dclk, nclk, pclk;
  logic [6:0] addr;
  logic [7:0] wdata, rdata;
  logic [8:0] ap, ai;
  logic [13:0] af;
  clk_tree_pkg::clk_inputs_type cin;
  clk_tree_pkg::pll_settings_type pll;
  clk_tree_pkg::clk_source_type ssrc, nsrc;
  int bad_count = 0;
  int check_count = 0;
  logic [2:0] scode [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
  logic [5:0] shot [5] = '{6'h20, 6'h10, 6'h04, 6'h02, 6'h01};
  logic [5:0] dhot [4] = '{6'h10, 6'h08, 6'h04, 6'h02};
  initial {auto, ap, ai, af, cin} = '0;

  always #4 clk_i = ~clk_i;

  clk_tree_host i_host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .ce_o(ce), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));
  clk_tree_cfg i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .wr_en_i(wr), .rd_en_i(rd), .addr_i(addr),
    .wdata_i(wdata), .auto_detect_i(auto), .auto_prescale_i(ap), .auto_int_i(ai), .auto_frac_i(af),
    .clk_in_i(cin), .rdata_o(rdata), .rvalid_o(rvalid), .pll_o(pll), .sec_div_clk_o(sclk), .dig_nm_clk_o(dclk),
    .nm_div_clk_o(nclk), .prescale_clk_o(pclk), .sec_src_o(ssrc), .nm_src_o(nsrc));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    i_host.rd(a, d, v);
    chk("rdata", d, e);
    chk("rvalid", v, 1'b1);
    @(posedge clk_i);
    #1;
    chk("rvalid end", rvalid, 1'b0);
  endtask

  // registered outputs lag a write by one edge; three leaves margin
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic results;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc(clk_tree_pkg::SEC_SRC_ADDR, 8'h00);
    rdc(clk_tree_pkg::NM_SRC_ADDR, 8'h10);
    rdc(clk_tree_pkg::PRESCALE_ADDR, 8'h01);
    rdc(clk_tree_pkg::MULT_UPPER_ADDR, 8'h00);
    rdc(clk_tree_pkg::INT_LOW_ADDR, 8'h08);
    rdc(clk_tree_pkg::FRAC_LOW_ADDR, 8'h00);
    rdc(clk_tree_pkg::PRE_SRC_ADDR, 8'h00);
    chk("frac", pll.frac_mult, 14'h0000);
    chk("manual", pll.manual, 1'b1);
    rdc(7'h40, 8'h00);
    chk("prescale", pll.prescale_div, 9'h001);
    chk("int", pll.int_mult, 9'h008);
  endtask

  task automatic t_mult;
    i_host.wr(clk_tree_pkg::PRESCALE_ADDR, 8'h00);
    i_host.wr(clk_tree_pkg::MULT_UPPER_ADDR, 8'hC5);
    i_host.wr(clk_tree_pkg::FRAC_LOW_ADDR, 8'h0A); // fraction 1290 stays legal
    i_host.wr(clk_tree_pkg::INT_LOW_ADDR, 8'h03);
    settle;
    chk("prescale", pll.prescale_div, 9'h100);
    chk("int", pll.int_mult, 9'h103);
    chk("halve", pll.halve, 1'b1);
    chk("frac", pll.frac_mult, 14'h050A);
    chk("flag", pll.reserved_setting, 1'b0);
    i_host.wr(clk_tree_pkg::MULT_UPPER_ADDR, 8'h00);
    i_host.wr(clk_tree_pkg::INT_LOW_ADDR, 8'h00);
    i_host.wr(clk_tree_pkg::PRESCALE_ADDR, 8'hFF);
    settle;
    chk("halve", pll.halve, 1'b0);
    chk("flag", pll.reserved_setting, 1'b1);
    chk("prescale", pll.prescale_div, 9'h0FF);
    i_host.wr(clk_tree_pkg::INT_LOW_ADDR, 8'h08);
    i_host.wr(clk_tree_pkg::MULT_UPPER_ADDR, 8'h27);
    i_host.wr(clk_tree_pkg::FRAC_LOW_ADDR, 8'h0F); // top legal fraction 9999
    settle;
    chk("frac", pll.frac_mult, 14'h270F);
    chk("flag", pll.reserved_setting, 1'b0);
    chk("int", pll.int_mult, 9'h008);
  endtask

  // a write offered with the clock enable low must change nothing
  task automatic t_freeze;
    i_host.wr_frozen(clk_tree_pkg::PRESCALE_ADDR, 8'h40);
    settle;
    chk("frozen prescale", pll.prescale_div, 9'h0FF);
    rdc(clk_tree_pkg::PRESCALE_ADDR, 8'hFF);
  endtask

  task automatic t_sources;
    for (int i = 0; i < 5; i++)
    begin
      i_host.wr(clk_tree_pkg::SEC_SRC_ADDR, {1'b0, scode[i], 4'h0});
      cin <= shot[i];
      settle;
      chk("sec src", ssrc, {1'b0, scode[i]});
      chk("sec clk", sclk, 1'b1);
    end
    for (int d = 0; d < 4; d++)
    begin
      i_host.wr(clk_tree_pkg::NM_SRC_ADDR, {d[1:0], 6'h20});
      i_host.wr(clk_tree_pkg::PRE_SRC_ADDR, {d[1:0], 6'h00});
      cin <= dhot[d];
      settle;
      chk("dig clk", dclk, 1'b1);
      chk("nm src", nsrc, clk_tree_pkg::SRC_DIGITAL);
      chk("nm clk", nclk, 1'b1);
      chk("pre clk", pclk, 1'b1);
    end
    i_host.wr(clk_tree_pkg::NM_SRC_ADDR, 8'h30);
    cin <= 6'h10;
    settle;
    chk("nm src", nsrc, clk_tree_pkg::SRC_PRIMARY);
    i_host.wr(clk_tree_pkg::NM_SRC_ADDR, 8'h00);
    cin <= 6'h20;
    settle;
    chk("nm src", nsrc, clk_tree_pkg::SRC_PLL);
    chk("nm clk", nclk, 1'b1);
    i_host.wr(clk_tree_pkg::NM_SRC_ADDR, 8'h10);
    settle;
    chk("nm src", nsrc, clk_tree_pkg::SRC_PLL);
    chk("nm clk", nclk, 1'b1);
    cin <= 6'h00;
    settle;
    chk("nm clk", nclk, 1'b0);
  endtask

  task automatic t_auto;
    @(posedge clk_i);
    {auto, ap, ai, af} <= {1'b1, 9'h0C0, 9'h1F0, 14'h1234};
    settle;
    chk("manual", pll.manual, 1'b0);
    chk("prescale", pll.prescale_div, 9'h0C0);
    chk("frac", pll.frac_mult, 14'h1234);
    chk("int", pll.int_mult, 9'h1F0);
    auto <= 1'b0;
    settle;
    chk("int", pll.int_mult, 9'h008);
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset;
    t_mult;
    t_freeze;
    t_sources;
    t_auto;
    results;
  end

  initial
  begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    results;
  end
endmodule // audio_clock_tree_pll_divider_config_tb

`default_nettype wire
